//--- core/cth_channel.sv
/*
  Channel end: runs selection, byte service, status and disconnect on the tags.
  Assumes inbound tags are asynchronous and are synchronised here.
*/
`timescale 1ns/1ps
`default_nettype none
`include "cth_params.svh"
// Behaviour
// - outbound lines valid only under interlock
// - interlock low resets every control unit
// - shared request line, many requesters tolerated
// - address-out makes units decode device address
// - address-out without select/hold disconnects unit
// - select-out daisy chain returns as select-in
// - units gate select-out with hold-out
// - hold-out only after interlock held 4us
// - operational-in marks selected device
// - address-in answered by command-out
// - command-out meaning depends on inbound tag
// - proceed/stack/stop drive zero command byte
// - status answered by service-out or command-out
// - service-out only acknowledges service/status in
// - every service-in gets an answer
// - service-in timing follows read or write
// - suppress line carries special functions
// - nine-line buses with odd parity (zero command bytes go out with parity bit 0)
// - outbound data held until inbound tag falls
// - inbound bus driven only under operational-in; a unit dropped by address-out keeps its last byte, except from US_STAT, where it clears to zero
module cth_channel
  import cth_pkg::*;
#(
  parameter int HOLD_MIN_CYC = `CTH_HOLD_MIN_CYC
) (
  input  wire logic            ref_clk,
  input  wire logic            rstn,
  cth_if.chan                  bus,
  input  wire logic            startValid,
  input  wire logic [7:0]      startAddr,
  input  wire logic [7:0]      startCmd,
  input  wire cth_op_t         startOp,
  output logic                 startReady,
  input  wire logic            wrValid,
  input  wire logic [7:0]      wrData,
  output logic                 wrReady,
  output logic                 rdValid,
  output logic [7:0]           rdData,
  input  wire logic            rdReady,
  input  wire logic            stopReq,
  input  wire logic            stackReq,
  input  wire logic            disconnectReq,
  input  wire logic            suppress,
  output logic                 statusValid,
  output logic [7:0]           statusByte,
  output logic                 parityErr,
  output logic                 busyOut
);
  typedef enum {CS_RESET, CS_IDLE, CS_SEL, CS_CMD, CS_CONN, CS_ANS, CS_DISC} cth_cs_t;
  cth_cs_t     state_reg;
  logic [1:0]  reqS_reg, adrS_reg, staS_reg, srvS_reg, oplS_reg, selS_reg;
  logic        adrD_reg, staD_reg, srvD_reg;
  logic [15:0] oplCnt_reg;
  logic        adrRise, staRise, srvRise, anyInFall;
  cth_op_t     op_reg;
  logic [7:0]  cmd_reg;
  // two-entry read buffer so a stalled consumer loses no byte
  logic [7:0]  rdMem [2];
  logic        rdWp_reg, rdRp_reg;
  logic [1:0]  rdCnt_reg;
  logic        rdPush;

  // inbound tags cross via two flops before use
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      {reqS_reg, adrS_reg, staS_reg, srvS_reg, oplS_reg, selS_reg} <= '0;
    end else begin
      reqS_reg <= {reqS_reg[0], bus.reqIn};
      adrS_reg <= {adrS_reg[0], bus.adrIn};
      staS_reg <= {staS_reg[0], bus.staIn};
      srvS_reg <= {srvS_reg[0], bus.srvIn};
      oplS_reg <= {oplS_reg[0], bus.oplIn};
      selS_reg <= {selS_reg[0], bus.selIn};
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      {adrD_reg, staD_reg, srvD_reg} <= '0;
    end else begin
      {adrD_reg, staD_reg, srvD_reg} <= {adrS_reg[1], staS_reg[1], srvS_reg[1]};
    end
  end
  assign adrRise   = adrS_reg[1] & ~adrD_reg;
  assign staRise   = staS_reg[1] & ~staD_reg;
  assign srvRise   = srvS_reg[1] & ~srvD_reg;
  assign anyInFall = (adrD_reg & ~adrS_reg[1]) | (staD_reg & ~staS_reg[1]) | (srvD_reg & ~srvS_reg[1]);

  always_ff @(posedge ref_clk) begin
    if (!rstn || !bus.oplOut) begin
      oplCnt_reg <= '0;
    end else if (oplCnt_reg != 16'hFFFF) begin
      oplCnt_reg <= oplCnt_reg + 16'h0001;
    end
  end

  assign rdPush = (state_reg == CS_ANS || (state_reg == CS_CONN && srvRise)) && (op_reg == CTH_OP_READ)
                  && (rdCnt_reg != 2'h2) && !stopReq;
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      rdWp_reg  <= 1'b0;
      rdRp_reg  <= 1'b0;
      rdCnt_reg <= 2'h0;
    end else begin
      if (rdPush) begin
        rdMem[rdWp_reg] <= bus.busIn.dat;
        rdWp_reg        <= ~rdWp_reg;
      end
      if (rdValid && rdReady) begin
        rdRp_reg <= ~rdRp_reg;
      end
      rdCnt_reg <= rdCnt_reg + {1'b0, rdPush} - {1'b0, rdValid & rdReady};
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      rdValid <= 1'b0;
      rdData  <= `CTH_ZERO_BYTE;
    end else begin
      rdValid <= (rdCnt_reg + {1'b0, rdPush} - {1'b0, rdValid & rdReady}) != 2'h0;
      rdData  <= (rdValid && rdReady) ? rdMem[~rdRp_reg] : rdMem[rdRp_reg];
      if (rdCnt_reg == 2'h0 || (rdCnt_reg == 2'h1 && rdValid && rdReady)) begin
        rdData <= bus.busIn.dat;
      end
    end
  end

  // main tag sequencer
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      state_reg   <= CS_RESET;
      bus.oplOut  <= 1'b0;
      bus.adrOut  <= 1'b0;
      bus.cmdOut  <= 1'b0;
      bus.srvOut  <= 1'b0;
      bus.holdOut <= 1'b0;
      bus.selOut  <= 1'b0;
      bus.supOut  <= 1'b0;
      bus.busOut  <= '{par: 1'b1, dat: `CTH_ZERO_BYTE};
      op_reg      <= CTH_OP_NONE;
      cmd_reg     <= `CTH_ZERO_BYTE;
      startReady  <= 1'b0;
      wrReady     <= 1'b0;
      statusValid <= 1'b0;
      statusByte  <= `CTH_ZERO_BYTE;
      parityErr   <= 1'b0;
      busyOut     <= 1'b0;
    end else begin
      startReady  <= 1'b0;
      wrReady     <= 1'b0;
      statusValid <= 1'b0;
      bus.supOut  <= suppress;
      bus.oplOut  <= 1'b1;
      bus.holdOut <= bus.oplOut && (oplCnt_reg >= 16'(HOLD_MIN_CYC));
      busyOut     <= (state_reg != CS_IDLE);
      if ((adrRise || staRise || srvRise) && bus.busIn.par != cthOddPar(bus.busIn.dat)) begin
        parityErr <= 1'b1;
      end
      if (anyInFall) begin
        bus.srvOut <= 1'b0;
        bus.cmdOut <= 1'b0;
      end
      case (state_reg)
        CS_RESET: begin
          if (bus.oplOut) state_reg <= CS_IDLE;
        end
        CS_IDLE: begin
          startReady <= bus.holdOut && !startValid;
          if (startValid && bus.holdOut) begin
            op_reg     <= startOp;
            cmd_reg    <= startCmd;
            bus.busOut <= '{par: cthOddPar(startAddr), dat: startAddr};
            bus.adrOut <= 1'b1;
            state_reg  <= CS_SEL;
          end else if (reqS_reg[1] && bus.holdOut) begin
            bus.selOut <= 1'b1;
            op_reg     <= CTH_OP_NONE;
            state_reg  <= CS_CONN;
          end
        end
        CS_SEL: begin
          bus.selOut <= 1'b1;
          if (oplS_reg[1] || selS_reg[1]) bus.adrOut <= 1'b0;
          if (selS_reg[1] && !oplS_reg[1]) begin
            bus.selOut <= 1'b0;
            state_reg  <= CS_IDLE;
          end else if (adrRise) begin
            bus.busOut <= '{par: cthOddPar(cmd_reg), dat: cmd_reg};
            bus.cmdOut <= 1'b1;
            startReady <= 1'b1;
            state_reg  <= CS_CONN;
          end
        end
        CS_CONN: begin
          if (disconnectReq && srvS_reg[1]) begin
            bus.selOut <= 1'b0;
            bus.adrOut <= 1'b1;
            state_reg  <= CS_DISC;
          end else if (staRise) begin
            statusByte <= bus.busIn.dat;
            if (stackReq) begin
              bus.busOut <= '{par: 1'b0, dat: `CTH_ZERO_BYTE};
              bus.cmdOut <= 1'b1;
              bus.selOut <= 1'b0;
            end else begin
              statusValid <= 1'b1;
              bus.srvOut  <= 1'b1;
              bus.selOut  <= 1'b0;
              state_reg   <= CS_DISC;
            end
          end else if (adrRise) begin
            bus.busOut <= '{par: 1'b0, dat: `CTH_ZERO_BYTE};
            bus.cmdOut <= 1'b1;
          end else if (srvRise) begin
            if (stopReq) begin
              bus.busOut <= '{par: 1'b0, dat: `CTH_ZERO_BYTE};
              bus.cmdOut <= 1'b1;
            end else if (op_reg == CTH_OP_WRITE) begin
              state_reg <= CS_ANS;
            end else if (rdPush) begin
              bus.srvOut <= 1'b1;
            end else begin
              state_reg <= CS_ANS;
            end
          end
          if (!oplS_reg[1] && !srvS_reg[1] && !staS_reg[1] && !adrS_reg[1] && op_reg != CTH_OP_NONE
              && bus.selOut == 1'b0) begin
            state_reg <= CS_IDLE;
          end
        end
        CS_ANS: begin
          // write byte needed, or read buffer full: wait without losing the pending service-in
          if (op_reg == CTH_OP_WRITE) begin
            wrReady <= wrValid && !wrReady;
            if (wrValid && !wrReady) begin
              bus.busOut <= '{par: cthOddPar(wrData), dat: wrData};
              bus.srvOut <= 1'b1;
              state_reg  <= CS_CONN;
            end
          end else if (rdCnt_reg != 2'h2) begin
            bus.srvOut <= 1'b1;
            state_reg  <= CS_CONN;
          end
          if (stopReq) begin
            bus.busOut <= '{par: 1'b0, dat: `CTH_ZERO_BYTE};
            bus.cmdOut <= 1'b1;
            wrReady    <= 1'b0;
            bus.srvOut <= 1'b0;
            state_reg  <= CS_CONN;
          end
        end
        CS_DISC: begin
          if (!oplS_reg[1] && !anyInFall && !srvS_reg[1] && !staS_reg[1]) begin
            bus.adrOut <= 1'b0;
            bus.srvOut <= 1'b0;
            state_reg  <= CS_IDLE;
          end
        end
        default: state_reg <= CS_RESET;
      endcase
    end
  end
endmodule : cth_channel
`default_nettype wire

//--- core/cth_params.svh
/*
  Timing counts and bus constants for the channel tag handshake.
  Assumes a 100 MHz ref_clk.
*/
`ifndef CTH_PARAMS_SVH
`define CTH_PARAMS_SVH
`define CTH_CLK_PERIOD_NS   10
`define CTH_HOLD_MIN_NS     4000
`define CTH_HOLD_MIN_CYC    ((`CTH_HOLD_MIN_NS + `CTH_CLK_PERIOD_NS - 1) / `CTH_CLK_PERIOD_NS)
`define CTH_DATA_W          8
`define CTH_ZERO_BYTE       8'h00
`define CTH_SYNC_STAGES     2
`endif

//--- core/cth_pkg.sv
/*
  Types shared by both ends of the channel tag handshake.
  Assumes cth_params.svh is on the include path.
*/
package cth_pkg;
  typedef enum logic [1:0] {CTH_OP_NONE, CTH_OP_READ, CTH_OP_WRITE} cth_op_t;
  typedef enum logic [1:0] {CTH_RSP_ACCEPT, CTH_RSP_STOP, CTH_RSP_STACK} cth_rsp_t;
  typedef struct packed {
    logic       par;
    logic [7:0] dat;
  } cth_byte_t;
  function automatic logic cthOddPar(input logic [7:0] b);
    cthOddPar = ~(^b);
  endfunction : cthOddPar
endpackage : cth_pkg

//--- core/cth_if.sv
/*
  Channel cable: outbound and inbound buses plus tag lines.
  Assumes a single control unit on the testbench side of the select loop.
*/
`timescale 1ns/1ps
`default_nettype none
interface cth_if;
  import cth_pkg::*;
  cth_byte_t busOut;
  cth_byte_t busIn;
  logic      oplOut;
  logic      adrOut;
  logic      cmdOut;
  logic      srvOut;
  logic      holdOut;
  logic      selOut;
  logic      supOut;
  logic      reqIn;
  logic      adrIn;
  logic      staIn;
  logic      srvIn;
  logic      oplIn;
  logic      selIn;
  modport chan (output busOut, oplOut, adrOut, cmdOut, srvOut, holdOut, selOut, supOut,
                input busIn, reqIn, adrIn, staIn, srvIn, oplIn, selIn);
  modport cu (input busOut, oplOut, adrOut, cmdOut, srvOut, holdOut, selOut, supOut,
              output busIn, reqIn, adrIn, staIn, srvIn, oplIn, selIn);
endinterface : cth_if
`default_nettype wire

//--- core/cth_ctrl_unit.sv
/*
  Control-unit end: one device behind the select loop.
  Assumes outbound tags are asynchronous and are synchronised here.
*/
`timescale 1ns/1ps
`default_nettype none
`include "cth_params.svh"
module cth_ctrl_unit
  import cth_pkg::*;
#(
  parameter logic [7:0] DEV_ADDR = 8'h01
) (
  input  wire logic       ref_clk,
  input  wire logic       rstn,
  cth_if.cu               bus,
  input  wire logic       wantService,
  input  wire logic [7:0] devStatus,
  input  wire logic [7:0] readByte,
  output logic            cmdValid,
  output logic [7:0]      cmdByte,
  output logic            writeValid,
  output logic [7:0]      writeByte,
  output logic            stopSeen,
  output logic            stackSeen,
  output logic            selected
);
  typedef enum {US_IDLE, US_ADDR, US_CMD, US_XFER, US_STAT} cth_us_t;
  cth_us_t    state_reg;
  logic [1:0] oplS_reg, adrS_reg, cmdS_reg, srvS_reg, holdS_reg, selS_reg;
  logic       gatedSel, srvD_reg, cmdD_reg, srvRise, cmdRise;
  logic [2:0] xferCnt_reg;

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      {oplS_reg, adrS_reg, cmdS_reg, srvS_reg, holdS_reg, selS_reg} <= '0;
      {srvD_reg, cmdD_reg} <= '0;
    end else begin
      oplS_reg  <= {oplS_reg[0], bus.oplOut};
      adrS_reg  <= {adrS_reg[0], bus.adrOut};
      cmdS_reg  <= {cmdS_reg[0], bus.cmdOut};
      srvS_reg  <= {srvS_reg[0], bus.srvOut};
      holdS_reg <= {holdS_reg[0], bus.holdOut};
      selS_reg  <= {selS_reg[0], bus.selOut};
      {srvD_reg, cmdD_reg} <= {srvS_reg[1], cmdS_reg[1]};
    end
  end
  assign gatedSel = selS_reg[1] & holdS_reg[1];
  assign srvRise  = srvS_reg[1] & ~srvD_reg;
  assign cmdRise  = cmdS_reg[1] & ~cmdD_reg;

  always_ff @(posedge ref_clk) begin
    if (!rstn || !oplS_reg[1]) begin
      state_reg   <= US_IDLE;
      bus.busIn   <= '{par: 1'b1, dat: `CTH_ZERO_BYTE};
      bus.reqIn   <= 1'b0;
      bus.adrIn   <= 1'b0;
      bus.staIn   <= 1'b0;
      bus.srvIn   <= 1'b0;
      bus.oplIn   <= 1'b0;
      bus.selIn   <= 1'b0;
      cmdValid    <= 1'b0;
      cmdByte     <= `CTH_ZERO_BYTE;
      writeValid  <= 1'b0;
      writeByte   <= `CTH_ZERO_BYTE;
      stopSeen    <= 1'b0;
      stackSeen   <= 1'b0;
      selected    <= 1'b0;
      xferCnt_reg <= 3'h0;
    end else begin
      cmdValid   <= 1'b0;
      writeValid <= 1'b0;
      stopSeen   <= 1'b0;
      stackSeen  <= 1'b0;
      bus.reqIn  <= wantService && state_reg == US_IDLE;
      selected   <= bus.oplIn;
      if (srvRise || cmdRise) begin
        bus.srvIn <= 1'b0;
        bus.staIn <= 1'b0;
      end
      case (state_reg)
        US_IDLE: begin
          bus.selIn <= gatedSel && !(adrS_reg[1] && bus.busOut.dat == DEV_ADDR) && !wantService;
          if (gatedSel && adrS_reg[1] && bus.busOut.dat == DEV_ADDR) begin
            bus.oplIn <= 1'b1;
            state_reg <= US_ADDR;
          end else if (gatedSel && wantService && !adrS_reg[1]) begin
            bus.oplIn <= 1'b1;
            state_reg <= US_ADDR;
          end
        end
        US_ADDR: begin
          if (!adrS_reg[1]) begin
            bus.busIn <= '{par: cthOddPar(DEV_ADDR), dat: DEV_ADDR};
            bus.adrIn <= 1'b1;
            state_reg <= US_CMD;
          end
        end
        US_CMD: begin
          if (cmdRise) begin
            bus.adrIn   <= 1'b0;
            cmdValid    <= 1'b1;
            cmdByte     <= bus.busOut.dat;
            xferCnt_reg <= 3'h0;
            state_reg   <= US_XFER;
          end
        end
        US_XFER: begin
          if (!bus.srvIn && !srvS_reg[1] && !cmdS_reg[1] && !srvRise && !cmdRise) begin
            if (xferCnt_reg == 3'h3) begin
              bus.busIn <= '{par: cthOddPar(devStatus), dat: devStatus};
              bus.staIn <= 1'b1;
              state_reg <= US_STAT;
            end else begin
              bus.busIn <= '{par: cthOddPar(readByte), dat: readByte};
              bus.srvIn <= 1'b1;
            end
          end
          if (srvRise) begin
            writeValid  <= 1'b1;
            writeByte   <= bus.busOut.dat;
            xferCnt_reg <= xferCnt_reg + 3'h1;
          end
          if (cmdRise) begin
            stopSeen    <= 1'b1;
            xferCnt_reg <= 3'h3;
          end
        end
        US_STAT: begin
          if (cmdRise) stackSeen <= 1'b1;
          if ((srvRise || cmdRise) || (adrS_reg[1] && !gatedSel)) begin
            bus.oplIn <= 1'b0;
            bus.busIn <= '{par: 1'b1, dat: `CTH_ZERO_BYTE};
            state_reg <= US_IDLE;
          end
        end
        default: state_reg <= US_IDLE;
      endcase
      if (state_reg != US_IDLE && adrS_reg[1] && !gatedSel && state_reg != US_ADDR) begin
        bus.oplIn <= 1'b0;
        bus.srvIn <= 1'b0;
        bus.staIn <= 1'b0;
        state_reg <= US_IDLE;
      end
    end
  end
endmodule : cth_ctrl_unit
`default_nettype wire

//--- verif/cth_sva.sv
/*
  Assertions on the cable between channel end and control-unit end.
  Assumes one unit on the cable, ref_clk and synchronous rstn.
*/
`timescale 1ns/1ps
`default_nettype none
`include "cth_params.svh"
module cth_sva
  import cth_pkg::*;
#(
  parameter int HOLD_MIN_CYC = `CTH_HOLD_MIN_CYC
) (
  input wire logic      ref_clk,
  input wire logic      rstn,
  input wire cth_byte_t busOut,
  input wire cth_byte_t busIn,
  input wire logic      oplOut,
  input wire logic      adrOut,
  input wire logic      cmdOut,
  input wire logic      srvOut,
  input wire logic      holdOut,
  input wire logic      selOut,
  input wire logic      reqIn,
  input wire logic      adrIn,
  input wire logic      staIn,
  input wire logic      srvIn,
  input wire logic      oplIn
);
  int oplCnt;
  // one cycle of slack for where the count starts
  always_ff @(posedge ref_clk) begin
    if (!rstn || !oplOut) oplCnt <= 0;
    else if (oplCnt < HOLD_MIN_CYC) oplCnt <= oplCnt + 1;
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  a_hold_after_opl: assert property (holdOut |-> oplCnt >= HOLD_MIN_CYC - 1)
    else $error("hold-out up too early");
  a_cmd_in_context: assert property ($rose(cmdOut) |-> adrIn || srvIn || staIn)
    else $error("command-out without inbound tag");
  a_cmd_zero_byte: assert property ($rose(cmdOut) && (srvIn || staIn) |-> busOut.dat == 8'h00)
    else $error("stop or stack byte not zero");
  a_srv_ack_only: assert property ($rose(srvOut) |-> srvIn || staIn)
    else $error("service-out without inbound tag");
  a_srvin_answered: assert property ($rose(srvIn) |-> ##[1:200] (srvOut || cmdOut || adrOut))
    else $error("service-in not answered");
  a_out_held: assert property ((srvOut || cmdOut) && $past(srvOut || cmdOut) && $past(srvIn || adrIn || staIn)
    |-> $stable(busOut))
    else $error("outbound byte changed early");
  a_addr_parity: assert property (adrOut && selOut |-> ^busOut)
    else $error("address byte parity even");
  a_in_parity: assert property (adrIn || staIn |-> ^busIn)
    else $error("inbound byte parity even");
  a_disc_drops_opl: assert property (adrOut && holdOut && !selOut |-> ##[1:8] !oplIn)
    else $error("unit stayed connected");
  a_opl_low_clears: assert property (!oplOut |-> ##[1:6] !(oplIn || adrIn || staIn || srvIn || reqIn))
    else $error("inbound tags up without interlock");
  a_addr_needs_opl: assert property ($rose(adrIn) |-> oplIn)
    else $error("address-in without operational-in");
endmodule : cth_sva
`default_nettype wire

//--- verif/channel_tag_handshake_tb.sv
/*
  Testbench: channel end and one control unit joined by the cable.
  Assumes cth_pkg and the design files are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checksDone++; if ((g) !== (e)) begin nFail++; \
  $display("unexpected %s expected %0h seen %0h", nm, e, g); end end
module channel_tag_handshake_tb
  import cth_pkg::*;
;
  logic       ref_clk, rstn, startValid, wrValid, rdReady, stopReq, stackReq, disconnectReq, wantService;
  logic [7:0] startAddr, startCmd, wrData, devStatus, readByte, rdData, statusByte, cmdByte, writeByte;
  cth_op_t    startOp;
  logic       startReady, wrReady, rdValid, statusValid, parityErr, busyOut;
  logic       cmdValid, writeValid, stopSeen, stackSeen, selected, suppress;
  logic [23:0] wrLog, rdLog;
  logic [7:0] cmdLast, staLast;
  int         nFail, checksDone, nStop, nStack, n;
  cth_if ifc();
  cth_channel #(.HOLD_MIN_CYC(4)) cth_channel_i (.ref_clk(ref_clk), .rstn(rstn), .bus(ifc),
    .startValid(startValid), .startAddr(startAddr), .startCmd(startCmd), .startOp(startOp),
    .startReady(startReady), .wrValid(wrValid), .wrData(wrData), .wrReady(wrReady), .rdValid(rdValid),
    .rdData(rdData), .rdReady(rdReady), .stopReq(stopReq), .stackReq(stackReq),
    .disconnectReq(disconnectReq), .suppress(suppress), .statusValid(statusValid), .statusByte(statusByte),
    .parityErr(parityErr), .busyOut(busyOut));
  cth_ctrl_unit #(.DEV_ADDR(8'h01)) cth_ctrl_unit_i (.ref_clk(ref_clk), .rstn(rstn), .bus(ifc),
    .wantService(wantService), .devStatus(devStatus), .readByte(readByte), .cmdValid(cmdValid),
    .cmdByte(cmdByte), .writeValid(writeValid), .writeByte(writeByte), .stopSeen(stopSeen),
    .stackSeen(stackSeen), .selected(selected));
  cth_sva #(.HOLD_MIN_CYC(4)) cth_sva_i (.ref_clk(ref_clk), .rstn(rstn), .busOut(ifc.busOut),
    .busIn(ifc.busIn), .oplOut(ifc.oplOut), .adrOut(ifc.adrOut), .cmdOut(ifc.cmdOut), .srvOut(ifc.srvOut),
    .holdOut(ifc.holdOut), .selOut(ifc.selOut), .reqIn(ifc.reqIn), .adrIn(ifc.adrIn), .staIn(ifc.staIn),
    .srvIn(ifc.srvIn), .oplIn(ifc.oplIn));
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // pulses are one cycle wide, so they are logged at the edge
  always @(posedge ref_clk) begin
    if (cmdValid === 1'b1) cmdLast = cmdByte;
    if (writeValid === 1'b1) wrLog = {wrLog[15:0], writeByte};
    if (rdValid === 1'b1 && rdReady) rdLog = {rdLog[15:0], rdData};
    if (statusValid === 1'b1) staLast = statusByte;
    if (stopSeen === 1'b1) nStop++;
    if (stackSeen === 1'b1) nStack++;
  end
  task automatic close_out();
    $display("comparisons %0d, mismatches %0d", checksDone, nFail);
    if (nFail == 0 && checksDone > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : close_out
  function automatic logic sig(input int s);
    case (s)
      0: sig = ifc.holdOut;
      1: sig = startReady;
      2: sig = wrReady;
      3: sig = !busyOut;
      4: sig = ifc.reqIn;
      5: sig = nStack > 0;
      6: sig = !selected;
      7: sig = nStop > 0;
      default: sig = ifc.srvIn;
    endcase
  endfunction : sig
  task automatic wait_hi(input int s, input int lim);
    for (n = 0; n < lim; n++) begin
      @(posedge ref_clk);
      if (sig(s) === 1'b1) break;
    end
    if (n == lim) begin
      nFail++;
      $display("unexpected timeout on wait %0d expected 1 seen 0", s);
      close_out();
    end
    #1;
  endtask : wait_hi
  task automatic start_op(input logic [7:0] cmd, input cth_op_t op);
    {wrLog, rdLog, cmdLast, staLast, nStop, nStack} = '0;
    startAddr = 8'h01;
    startCmd = cmd;
    startOp = op;
    startValid = 1'b1;
    wait_hi(1, 200);
    startValid = 1'b0;
  endtask : start_op
  task automatic put_byte(input logic [7:0] b);
    wrData = b;
    wrValid = 1'b1;
    wait_hi(2, 200);
  endtask : put_byte
  initial begin
    {rstn, startValid, wrValid, rdReady, stopReq, stackReq, disconnectReq, wantService, suppress} = '0;
    {startAddr, startCmd, wrData} = '0;
    startOp = CTH_OP_NONE;
    devStatus = 8'h0C;
    readByte = 8'hA5;
    {nFail, checksDone} = '0;
    repeat (16) @(posedge ref_clk);
    #1 rstn = 1'b1;
    wait_hi(0, 1000);
    `CHK("hold delay", 1'b1, n >= 4)
    start_op(8'h01, CTH_OP_WRITE);
    put_byte(8'h11);
    put_byte(8'h22);
    put_byte(8'h37);
    wrValid = 1'b0;
    wait_hi(3, 300);
    `CHK("write command", 8'h01, cmdLast)
    `CHK("write bytes", 24'h112237, wrLog)
    `CHK("write status", devStatus, staLast)
    // receiver stalls long enough to fill the two-entry buffer
    start_op(8'h02, CTH_OP_READ);
    repeat (80) @(posedge ref_clk);
    #1 rdReady = 1'b1;
    wait_hi(3, 300);
    `CHK("read bytes", 24'hA5A5A5, rdLog)
    `CHK("read status", devStatus, staLast)
    stopReq = 1'b1;
    start_op(8'h01, CTH_OP_WRITE);
    wait_hi(7, 300);
    stopReq = 1'b0;
    wait_hi(3, 300);
    `CHK("stop count", 1, nStop)
    stackReq = 1'b1;
    start_op(8'h02, CTH_OP_READ);
    wait_hi(5, 300);
    stackReq = 1'b0;
    wait_hi(3, 500);
    `CHK("stack seen", 1'b1, nStack > 0)
    start_op(8'h01, CTH_OP_WRITE);
    wait_hi(8, 300);
    disconnectReq = 1'b1;
    wait_hi(6, 100);
    disconnectReq = 1'b0;
    wait_hi(3, 300);
    `CHK("selected after disconnect", 1'b0, selected)
    `CHK("parity error", 1'b0, parityErr)
    wantService = 1'b1;
    wait_hi(4, 50);
    `CHK("request line", 1'b1, ifc.reqIn)
    // unit-initiated connection: address-in is answered by a zero proceed byte
    wait_hi(8, 300);
    wantService = 1'b0;
    `CHK("proceed byte", 8'h00, cmdLast)
    wait_hi(3, 300);
    `CHK("suppress idle", 1'b0, ifc.supOut)
    suppress = 1'b1;
    repeat (2) @(posedge ref_clk);
    #1 `CHK("suppress line", 1'b1, ifc.supOut)
    close_out();
  end
endmodule : channel_tag_handshake_tb
`default_nettype wire
